// File: core/ascp_pkg.sv
// Constants shared by the serial command port of the converter
package ascp_pkg;
  // Configuration register indices
  localparam logic [1:0] REG_INPUT_AMP = 2'h0;
  localparam logic [1:0] REG_RATE_CONV = 2'h1;
  localparam logic [1:0] REG_REF_FILT = 2'h2;
  localparam logic [1:0] REG_ROUTE_RDY = 2'h3;
  localparam int REG_COUNT = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Register 0 field positions
  localparam int INPUT_SELECT_LSB = 4;
  localparam int AMP_FACTOR_LSB = 1;
  localparam int AMP_SKIP_BIT = 0;
  localparam logic [2:0] AMP_FORCED_MIN = 3'h3;
  // Register 1 field positions
  localparam int RATE_SELECT_LSB = 5;
  localparam int OP_MODE_LSB = 3;
  localparam int CONTINUOUS_BIT = 2;
  localparam int TEMP_SENSE_BIT = 1;
  localparam int BURNOUT_BIT = 0;
  // Register 3 field positions
  localparam int READY_ON_DOUT_BIT = 1;
  localparam logic [7:0] REG3_WRITE_MASK = 8'hFE;
  // Command opcodes in the high nibble
  localparam logic [3:0] CMD_READ_RESULT = 4'h1;
  localparam logic [3:0] CMD_REG_READ = 4'h2;
  localparam logic [3:0] CMD_REG_WRITE = 4'h4;
  // Link framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [5:0] RESULT_BITS = 6'h10;
  localparam int RESULT_W = 16;
  localparam int OUT_W = 32;
  localparam int BUF_DEPTH = 2;
  // Command decoder states
  typedef enum logic [1:0] {
    ASCP_DECODE,
    ASCP_BUSY,
    ASCP_WDATA
  } ascp_cmd_e;
endpackage

// File: core/ascp_buf.sv
// Two-entry valid/ready buffer for conversion results
`timescale 1ns/1ps
`default_nettype none
module ascp_buf #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers, fill count and registered ready
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
        in_ready <= cnt_r != (AW + 1)'(DEPTH - 1);
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
        in_ready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/ascp_port.sv
// Serial command port: command decode, result shifting, config registers
//
// Behaviour
// R1: Decode commands on the input while result bits shift out, full duplex.
// R2: Accept a command on any byte boundary of a result read.
// R3: Register or result read command aborts a result read unless in its last byte.
// R4: Requested data starts on the first rising clock after the command byte.
// R5: Host keeps serial input low to read results without sending commands.
// R6: Register write during a result read leaves the read intact.
// R7: After a complete register write, pulse filter restart with new settings.
// R8: Commands ignored while read executes; host reads all bits first.
// R9: Output pin tri-stated whenever chip select is high.
// R10: Ready flag pin is driven at all times.
// R11: Chip select low with ready mode makes output show ready state at once.
// R12: Polling host clocks eight bits low then eight high after each read.
// R13: Host gives each device on a shared bus its own chip select.
// R14: Four 8-bit config registers reached only by read and write commands.
// R15: All config bits clear to zero on reset.
// R16: Config registers keep their contents in power-down.
// R17: Register 0 holds input select, amplifier factor and amplifier skip.
// R18: Amplifier stays enabled for factors 8 to 128 whatever the skip bit.
// R19: Host sets skip and low gains for single-ended inputs.
// R20: Register 1 holds rate, mode, continuous, temp sense and burnout bits.
// R21: Register 3 bit 0 reads zero and ignores writes.
// R22: Opcodes 0010 read, 0100 write, 0001 result; low bits address and count.
// R23: Config updates on the last falling clock of the write's last byte.
// R24: Results shift out on rising clocks, most significant bit first, two bytes.
// R25: Result read command loads the latest result into the shifter.
`timescale 1ns/1ps
`default_nettype none
module ascp_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Serial link pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  output logic dout_pin,
  output logic dout_oe_n,
  output logic ready_flag_n_pin,
  // Conversion results
  input wire logic [ascp_pkg::RESULT_W-1:0] conv_data,
  input wire logic conv_valid,
  output logic conv_ready,
  // Converter control
  output logic [7:0] cfg_input_amp,
  output logic [7:0] cfg_rate_conv,
  output logic [7:0] cfg_ref_filt,
  output logic [7:0] cfg_route_rdy,
  output logic amp_enable,
  output logic filter_restart
);
  import ascp_pkg::*;

  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic cs_s1_r, cs_s2_r;
  logic din_s1_r, din_s2_r;
  logic rise, fall, link_on, byte_done;
  logic [2:0] fall_cnt_r;
  logic [7:0] in_sh_r;
  logic [7:0] in_byte;
  logic [3:0] op;
  logic [1:0] rr;
  logic [1:0] nn;
  logic dec, ld_rdata, ld_register_read_cmd, go_register_write_cmd, wr_last, res_start, pop;
  ascp_cmd_e cst_r;
  logic [1:0] wr_addr_r;
  logic [1:0] wr_left_r;
  logic [7:0] pend_r [REG_COUNT];
  logic [REG_COUNT-1:0] pend_we_r;
  logic [7:0] cfg_r [REG_COUNT];
  logic [OUT_W-1:0] out_sh_r;
  logic [5:0] out_left_r;
  logic bit_r, hold_r;
  logic [RESULT_W-1:0] lat_res_r;
  logic new_data_r;
  logic buf_valid;
  logic [RESULT_W-1:0] buf_data;

  // Keep register 3 bit 0 at zero
  function automatic logic [7:0] reg_mask(input logic [1:0] idx, input logic [7:0] v);
    reg_mask = (idx == REG_ROUTE_RDY) ? (v & REG3_WRITE_MASK) : v; // R21
  endfunction

  // Gather all four registers from a start index, wrapping
  function automatic logic [OUT_W-1:0] reg_word(input logic [1:0] start);
    logic [1:0] idx;
    reg_word = '0;
    for (int k = 0; k < REG_COUNT; k++) begin
      idx = start + 2'(k);
      reg_word[OUT_W-1-8*k -: 8] = cfg_r[idx];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two flops per pin, third clock stage for edge finding
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= sclk_pin;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r <= cs_n_pin;
      cs_s2_r <= cs_s1_r;
      din_s1_r <= din_pin;
      din_s2_r <= din_s1_r;
    end
  end

  // Link edges and command decode
  always_comb begin
    link_on = !cs_s2_r;
    rise = link_on && sclk_s2_r && !sclk_s3_r;
    fall = link_on && !sclk_s2_r && sclk_s3_r;
    byte_done = fall && (fall_cnt_r == BIT_LAST);
    in_byte = {in_sh_r[6:0], din_s2_r};
    op = in_byte[7:4]; // R22
    rr = in_byte[3:2];
    nn = in_byte[1:0];
    dec = byte_done && (cst_r == ASCP_DECODE); // R1 R2
    ld_rdata = dec && (op == CMD_READ_RESULT);
    ld_register_read_cmd = dec && (op == CMD_REG_READ);
    go_register_write_cmd = dec && (op == CMD_REG_WRITE);
    wr_last = byte_done && (cst_r == ASCP_WDATA) && (wr_left_r == 2'h0);
    res_start = rise && (out_left_r == 6'h00) && (cst_r == ASCP_DECODE)
                && (fall_cnt_r == 3'h0) && new_data_r;
    pop = buf_valid && (out_left_r == 6'h00);
  end

  ////////////////////////////////////////////////////////////////////////
  // Input side

  // Bit counter and input shifter, sampled on falling clocks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fall_cnt_r <= 3'h0;
      in_sh_r <= 8'h00;
    end else if (!link_on) begin
      fall_cnt_r <= 3'h0;
    end else if (fall) begin
      fall_cnt_r <= fall_cnt_r + 3'h1;
      in_sh_r <= in_byte;
    end
  end

  // Command state, write collection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cst_r <= ASCP_DECODE;
      wr_addr_r <= 2'h0;
      wr_left_r <= 2'h0;
      pend_we_r <= '0;
      for (int k = 0; k < REG_COUNT; k++) begin
        pend_r[k] <= REG_RESET;
      end
    end else if (!link_on) begin
      cst_r <= ASCP_DECODE;
      pend_we_r <= '0;
    end else if (byte_done) begin
      unique case (cst_r)
        ASCP_DECODE: begin
          if (ld_rdata || ld_register_read_cmd) begin
            cst_r <= ASCP_BUSY; // R8
          end else if (go_register_write_cmd) begin
            cst_r <= ASCP_WDATA; // R6
            wr_addr_r <= rr;
            wr_left_r <= nn;
            pend_we_r <= '0;
          end
        end
        ASCP_BUSY: begin
          if (out_left_r == 6'h00) begin
            cst_r <= ASCP_DECODE; // R8
          end
        end
        ASCP_WDATA: begin
          pend_r[wr_addr_r] <= in_byte;
          pend_we_r[wr_addr_r] <= 1'b1;
          wr_addr_r <= wr_addr_r + 2'h1;
          if (wr_left_r == 2'h0) begin
            cst_r <= ASCP_DECODE;
          end else begin
            wr_left_r <= wr_left_r - 2'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Commit all written bytes together on the last falling clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        cfg_r[k] <= REG_RESET; // R15
      end
    end else if (wr_last) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        if (2'(k) == wr_addr_r) begin
          cfg_r[k] <= reg_mask(2'(k), in_byte); // R14 R23
        end else if (pend_we_r[k]) begin
          cfg_r[k] <= reg_mask(2'(k), pend_r[k]); // R23
        end
      end
    end
  end

  // Restart pulse and amplifier enable toward the converter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      filter_restart <= 1'b0;
      amp_enable <= 1'b1;
    end else begin
      filter_restart <= wr_last; // R7
      amp_enable <= !cfg_r[REG_INPUT_AMP][AMP_SKIP_BIT]
                    || (cfg_r[REG_INPUT_AMP][AMP_FACTOR_LSB +: 3] >= AMP_FORCED_MIN); // R17 R18
    end
  end

  // Field view of the registers; no power-down path touches them
  assign cfg_input_amp = cfg_r[REG_INPUT_AMP]; // R16 R17
  assign cfg_rate_conv = cfg_r[REG_RATE_CONV]; // R20
  assign cfg_ref_filt = cfg_r[REG_REF_FILT];
  assign cfg_route_rdy = cfg_r[REG_ROUTE_RDY];

  ////////////////////////////////////////////////////////////////////////
  // Results

  ascp_buf #(
    .W(RESULT_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_data),
    .out_valid(buf_valid),
    .out_ready(out_left_r == 6'h00),
    .out_data(buf_data)
  );

  // Latest result, taken from the buffer only between reads
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lat_res_r <= '0;
    end else if (pop) begin
      lat_res_r <= buf_data;
    end
  end

  // Unread-result flag, a new result wins over the read that clears it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      new_data_r <= 1'b0;
    end else if (pop) begin
      new_data_r <= 1'b1;
    end else if (res_start || ld_rdata) begin
      new_data_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output shifter

  // Load on command byte end, shift on rising clocks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_sh_r <= '0;
      out_left_r <= 6'h00;
      bit_r <= 1'b1;
      hold_r <= 1'b0;
    end else if (!link_on) begin
      out_left_r <= 6'h00;
      hold_r <= 1'b0;
    end else if (ld_rdata) begin
      out_sh_r <= {lat_res_r, 16'h0000}; // R25 R3
      out_left_r <= RESULT_BITS;
    end else if (ld_register_read_cmd) begin
      out_sh_r <= reg_word(rr); // R3 R14
      out_left_r <= {3'(nn) + 3'h1, 3'h0};
    end else if (res_start) begin
      bit_r <= lat_res_r[RESULT_W-1]; // R24
      out_sh_r <= {lat_res_r[RESULT_W-2:0], 17'h00000};
      out_left_r <= RESULT_BITS - 6'h01;
      hold_r <= 1'b0;
    end else if (rise && (out_left_r != 6'h00)) begin
      bit_r <= out_sh_r[OUT_W-1]; // R4 R24
      out_sh_r <= {out_sh_r[OUT_W-2:0], 1'b0};
      out_left_r <= out_left_r - 6'h01;
      hold_r <= out_left_r == 6'h01;
    end else if (fall) begin
      hold_r <= 1'b0;
    end
  end

  // Pin drivers: data bit while shifting, ready state when idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dout_pin <= 1'b1;
      dout_oe_n <= 1'b1;
      ready_flag_n_pin <= 1'b1;
    end else begin
      dout_oe_n <= cs_s2_r; // R9
      ready_flag_n_pin <= !new_data_r; // R10
      if ((out_left_r == 6'h00) && !hold_r
          && cfg_r[REG_ROUTE_RDY][READY_ON_DOUT_BIT]) begin
        dout_pin <= !new_data_r; // R11
      end else begin
        dout_pin <= bit_r;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/ascp_chk.sv
// Assertion checker for the serial command port
`timescale 1ns/1ps
`default_nettype none
module ascp_chk
  import ascp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Link pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  input wire logic dout_pin,
  input wire logic dout_oe_n,
  input wire logic ready_flag_n_pin,
  // Results
  input wire logic [ascp_pkg::RESULT_W-1:0] conv_data,
  input wire logic conv_valid,
  input wire logic conv_ready,
  // Converter control
  input wire logic [7:0] cfg_input_amp,
  input wire logic [7:0] cfg_rate_conv,
  input wire logic [7:0] cfg_ref_filt,
  input wire logic [7:0] cfg_route_rdy,
  input wire logic amp_enable,
  input wire logic filter_restart
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Pin enable against chip select
  a_oe_off_idle: assert property (cs_n_pin [*5] |-> dout_oe_n)
    else $error("output driven while deselected");
  a_oe_on_sel: assert property ((!cs_n_pin) [*5] |-> !dout_oe_n)
    else $error("output not driven while selected");
  // Register contents
  a_reg3_bit0: assert property (cfg_route_rdy[0] == 1'b0)
    else $error("register 3 bit 0 set");
  a_cfg_quiet: assert property (cs_n_pin [*8] |-> $stable({cfg_input_amp, cfg_rate_conv, cfg_ref_filt, cfg_route_rdy}))
    else $error("config changed while deselected");
  // Amplifier enable
  a_amp_forced: assert property ($past(cfg_input_amp[3:1]) >= AMP_FORCED_MIN |-> amp_enable)
    else $error("amplifier off at high gain");
  a_amp_skip: assert property ($past(cfg_input_amp[0]) && $past(cfg_input_amp[3:1]) < AMP_FORCED_MIN |-> !amp_enable)
    else $error("amplifier on despite skip");
  // Filter restart
  a_restart_pulse: assert property (filter_restart |=> !filter_restart)
    else $error("restart longer than one cycle");
  a_restart_cause: assert property (!$stable({cfg_input_amp, cfg_rate_conv, cfg_ref_filt, cfg_route_rdy}) |-> filter_restart)
    else $error("no restart after config update");
  // New result raises the flag
  a_flag_on_push: assert property (conv_valid && conv_ready |-> ##[1:1000] !ready_flag_n_pin)
    else $error("ready flag not shown");
endmodule
bind ascp_port ascp_chk chk (.*);
`default_nettype wire

// File: test/ascp_host.sv
// Host controller model driving the serial link in mode 1
`timescale 1ns/1ps
`default_nettype none
module ascp_host (
  // System clock
  input wire logic ref_clk,
  // Link pins
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic din_pin,
  input wire logic dout_pin,
  input wire logic dout_oe_n
);
  logic seen = 1'b0;
  // Released line toggles, never keeps the last bit
  always @(negedge ref_clk) seen <= dout_oe_n ? ~seen : dout_pin;
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    din_pin = 1'b0;
  end
  // Own chip select per device, input toggled when deselected
  task sel(input logic v);
    @(negedge ref_clk);
    cs_n_pin = v;
    if (v) din_pin = ~din_pin;
    repeat (8) @(negedge ref_clk);
  endtask
  // Data set at rising clock, read back at falling clock
  task xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge ref_clk);
      sclk_pin = 1'b1;
      din_pin = tx[i];
      repeat (8) @(negedge ref_clk);
      sclk_pin = 1'b0;
      rx = {rx[30:0], seen};
      repeat (7) @(negedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking testbench of the serial command port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ascp_pkg::*;
  logic ref_clk, rstn, conv_valid;
  logic [15:0] conv_data;
  wire sclk_pin, cs_n_pin, din_pin, dout_pin, dout_oe_n, ready_flag_n_pin, conv_ready, amp_enable, filter_restart;
  wire [7:0] cfg_input_amp, cfg_rate_conv, cfg_ref_filt, cfg_route_rdy;
  logic [31:0] rx;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int restarts = 0;
  ////////////////////////////////////////////////////////////
  ascp_port dut (.ref_clk(ref_clk), .rstn(rstn), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .din_pin(din_pin),
    .dout_pin(dout_pin), .dout_oe_n(dout_oe_n), .ready_flag_n_pin(ready_flag_n_pin), .conv_data(conv_data),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .cfg_input_amp(cfg_input_amp), .cfg_rate_conv(cfg_rate_conv),
    .cfg_ref_filt(cfg_ref_filt), .cfg_route_rdy(cfg_route_rdy), .amp_enable(amp_enable),
    .filter_restart(filter_restart));
  ascp_host host (.ref_clk(ref_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .din_pin(din_pin),
    .dout_pin(dout_pin), .dout_oe_n(dout_oe_n));
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // Restart pulses seen
  always @(posedge ref_clk) begin
    if (filter_restart === 1'b1) restarts++;
  end
  ////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task print_verdict;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hand one result over the valid/ready port
  task push(input logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    conv_data = d;
    conv_valid = 1'b1;
    while (conv_ready !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    conv_valid = 1'b0;
  endtask
  function automatic logic [31:0] cfg_all();
    return {cfg_input_amp, cfg_rate_conv, cfg_ref_filt, cfg_route_rdy};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    conv_valid = 1'b0;
    conv_data = '0;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    chk("cfg", 32'h0, cfg_all());
    chk("oe", 32'h1, dout_oe_n);
    // Write all four registers, then read back and wrap
    host.sel(0);
    host.xfer(8, 32'h43, rx);
    host.xfer(32, 32'h5A3CC3FF, rx);
    host.sel(1);
    chk("cfg", 32'h5A3CC3FE, cfg_all());
    chk("restart", 32'h1, restarts);
    host.sel(0);
    host.xfer(8, 32'h23, rx);
    host.xfer(32, 32'h0, rx);
    host.sel(1);
    chk("rd_all", 32'h5A3CC3FE, rx);
    host.sel(0);
    host.xfer(24, 32'h2D0000, rx);
    host.sel(1);
    chk("rd_wrap", 32'hFE5A, rx[15:0]);
    // Result read without command
    push(16'hA5C3);
    repeat (10) @(negedge ref_clk);
    chk("flag", 32'h0, ready_flag_n_pin);
    host.sel(0);
    chk("dout_rdy", 32'h0, {dout_oe_n, dout_pin});
    host.xfer(16, 32'h0, rx);
    host.sel(1);
    chk("result", 32'hA5C3, rx);
    chk("flag", 32'h1, ready_flag_n_pin);
    // Result command in the first byte restarts the read
    push(16'h0F0F);
    host.sel(0);
    host.xfer(24, 32'h100000, rx);
    host.sel(1);
    chk("rdata", 32'h0F0F, rx[15:0]);
    // Write alongside a result read
    push(16'h1234);
    host.sel(0);
    host.xfer(24, 32'h402100, rx);
    host.sel(1);
    chk("rd_wr", 32'h1234, rx[23:8]);
    chk("cfg0", 32'h21, cfg_input_amp);
    chk("amp", 32'h0, amp_enable);
    host.sel(0);
    host.xfer(16, 32'h4037, rx);
    host.sel(1);
    chk("amp", 32'h1, amp_enable);
    // Fill the buffer while a command read shifts out
    fork
      begin
        host.sel(0);
        host.xfer(24, 32'h104155, rx);
        host.sel(1);
      end
      begin
        repeat (200) @(negedge ref_clk);
        push(16'h1111);
        push(16'h2222);
        repeat (3) @(negedge ref_clk);
        chk("full", 32'h0, conv_ready);
        push(16'h3333);
      end
    join
    chk("rdata", 32'h1234, rx[15:0]);
    chk("cfg0", 32'h37, cfg_input_amp);
    repeat (20) @(negedge ref_clk);
    host.sel(0);
    chk("dout_rdy", 32'h0, {dout_oe_n, dout_pin});
    host.xfer(32, 32'h0, rx);
    host.sel(1);
    chk("result", 32'h3333FFFF, rx);
    chk("flag", 32'h1, ready_flag_n_pin);
    chk("restart", 32'h3, restarts);
    print_verdict();
  end
endmodule
`default_nettype wire
